// ===== design/tpx_pin_cond.sv
/*
 * pin conditioner: two-flop synchroniser plus falling-edge detection.
 * assumes the pin is asynchronous to clk and idles high.
 */
`timescale 1ns/1ps
module tpx_pin_cond
    import tpx_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // raw pin
    input  wire logic pinRaw,
    // conditioned pin
    tpx_pin_if.src    out
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // ------------------------------------------------------------
    // synchroniser; meta_r feeds sync_r only
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= pinRaw;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // one strike per transition, since only settled samples are compared
    assign out.level = sync_r;
    assign out.fall  = prev_r & ~sync_r;
endmodule

// ===== design/tpx_pin_if.sv
/*
 * interface carrying one synchronised pin and its falling-edge strike from
 * the conditioner to the main block. assumes one core clock.
 */
`timescale 1ns/1ps
interface tpx_pin_if;
    logic level;
    logic fall;
    modport src (output level, output fall);
    modport dst (input level, input fall);
endinterface

// ===== design/tpx_pkg.sv
/*
 * package for the timer pin input block: control bit layout, reset values
 * and widths. assumes nothing beyond a single core clock domain.
 */
package tpx_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int TPX_COUNT_W  = 16;
    localparam int TPX_SYNC_LEN = 2;

    // ------------------------------------------------------------
    // timer control register layout (8 bits)
    // ------------------------------------------------------------
    localparam int TPX_CTRL_W      = 8;
    localparam int TPX_BIT_EDGE_A  = 0;
    localparam int TPX_BIT_PEND_A  = 1;
    localparam int TPX_BIT_EDGE_B  = 2;
    localparam int TPX_BIT_PEND_B  = 3;
    localparam logic [TPX_CTRL_W-1:0] TPX_CTRL_RESET = 8'h00;
    localparam logic [TPX_COUNT_W-1:0] TPX_COUNT_RESET = 16'h0000;

    // ------------------------------------------------------------
    // per-line pin mode
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TPX_DET_LEVEL = 2'b01,
        TPX_DET_EDGE  = 2'b10
    } tpx_det_t;
endpackage

// ===== design/tpx_timer_pins.sv
/*
 * input side of two 16-bit timers and two external interrupt lines:
 * gate control, pending flags and external count input.
 * assumes pins are asynchronous; mode/run bits come from core logic on clk.
 */
`timescale 1ns/1ps
// How it works
// - with its gate-select set, a timer runs only while its interrupt pin is high.
// - with edge select set, a falling edge on the interrupt pin sets the pending flag.
// - with edge select clear, a low sampled level on the interrupt pin sets the pending flag.
// - a running timer in counter mode steps by one on each falling edge of its count pin.
// - pending flags and edge-select bits live in the timer control register.
module tpx_timer_pins
    import tpx_pkg::*;
#(
    parameter int COUNT_W = TPX_COUNT_W
)
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // pins
    input  wire logic                  ext_irq_pin_a,
    input  wire logic                  ext_irq_pin_b,
    input  wire logic                  timer_a_count_pin,
    input  wire logic                  timer_b_count_pin,
    // timer configuration
    input  wire logic                  timer_a_run,
    input  wire logic                  timer_b_run,
    input  wire logic                  timer_a_gate_sel,
    input  wire logic                  timer_b_gate_sel,
    input  wire logic                  timer_a_counter_mode,
    input  wire logic                  timer_b_counter_mode,
    // control register write and pending acknowledge
    input  wire logic                  ctrlWrEn,
    input  wire logic [TPX_CTRL_W-1:0] ctrlWrData,
    input  wire logic                  ext_irq_ack_a,
    input  wire logic                  ext_irq_ack_b,
    // status
    output logic [TPX_CTRL_W-1:0]      timer_control_reg,
    output logic                       ext_irq_pending_a,
    output logic                       ext_irq_pending_b,
    output logic                       timerARunning,
    output logic                       timerBRunning,
    output logic [COUNT_W-1:0]         timerACount,
    output logic [COUNT_W-1:0]         timerBCount
);
    // counter wider than 32 bits is not served by the step logic
    if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_width
        $error("COUNT_W out of range");
    end

    // ------------------------------------------------------------
    // pin conditioning
    // ------------------------------------------------------------
    tpx_pin_if irqA ();
    tpx_pin_if irqB ();
    tpx_pin_if cntA ();
    tpx_pin_if cntB ();

    tpx_pin_cond u_irq_a (.clk(clk), .rst(rst), .pinRaw(ext_irq_pin_a),     .out(irqA));
    tpx_pin_cond u_irq_b (.clk(clk), .rst(rst), .pinRaw(ext_irq_pin_b),     .out(irqB));
    tpx_pin_cond u_cnt_a (.clk(clk), .rst(rst), .pinRaw(timer_a_count_pin), .out(cntA));
    tpx_pin_cond u_cnt_b (.clk(clk), .rst(rst), .pinRaw(timer_b_count_pin), .out(cntB));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic pendNext(input logic cur, input logic edgeSel, input logic lvl,
                                      input logic fall, input logic clr);
        logic hit;
        hit = edgeSel ? fall : ~lvl;
        // a detection in the same cycle as a clear keeps the flag
        pendNext = hit | (cur & ~clr);
    endfunction

    function automatic logic runNext(input logic run, input logic gateSel, input logic lvl);
        runNext = run & (~gateSel | lvl);
    endfunction

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    logic edgeSelA_r;
    logic edgeSelB_r;
    logic pendA_r;
    logic pendB_r;
    tpx_det_t detA;
    tpx_det_t detB;

    assign detA = edgeSelA_r ? TPX_DET_EDGE : TPX_DET_LEVEL;
    assign detB = edgeSelB_r ? TPX_DET_EDGE : TPX_DET_LEVEL;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            edgeSelA_r <= TPX_CTRL_RESET[TPX_BIT_EDGE_A];
            edgeSelB_r <= TPX_CTRL_RESET[TPX_BIT_EDGE_B];
        end else if (ctrlWrEn) begin
            edgeSelA_r <= ctrlWrData[TPX_BIT_EDGE_A];
            edgeSelB_r <= ctrlWrData[TPX_BIT_EDGE_B];
        end
    end

    // pending flags: cleared by writing zero or by acknowledge, set wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pendA_r <= TPX_CTRL_RESET[TPX_BIT_PEND_A];
            pendB_r <= TPX_CTRL_RESET[TPX_BIT_PEND_B];
        end else begin
            pendA_r <= pendNext(pendA_r, detA == TPX_DET_EDGE, irqA.level, irqA.fall,
                                ext_irq_ack_a | (ctrlWrEn & ~ctrlWrData[TPX_BIT_PEND_A]));
            pendB_r <= pendNext(pendB_r, detB == TPX_DET_EDGE, irqB.level, irqB.fall,
                                ext_irq_ack_b | (ctrlWrEn & ~ctrlWrData[TPX_BIT_PEND_B]));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_control_reg <= TPX_CTRL_RESET;
            ext_irq_pending_a <= 1'b0;
            ext_irq_pending_b <= 1'b0;
        end else begin
            timer_control_reg                 <= TPX_CTRL_RESET;
            timer_control_reg[TPX_BIT_EDGE_A] <= edgeSelA_r;
            timer_control_reg[TPX_BIT_PEND_A] <= pendA_r;
            timer_control_reg[TPX_BIT_EDGE_B] <= edgeSelB_r;
            timer_control_reg[TPX_BIT_PEND_B] <= pendB_r;
            ext_irq_pending_a                 <= pendA_r;
            ext_irq_pending_b                 <= pendB_r;
        end
    end

    // ------------------------------------------------------------
    // gate and counters
    // ------------------------------------------------------------
    logic runA;
    logic runB;
    assign runA = runNext(timer_a_run, timer_a_gate_sel, irqA.level);
    assign runB = runNext(timer_b_run, timer_b_gate_sel, irqB.level);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timerARunning <= 1'b0;
            timerBRunning <= 1'b0;
        end else begin
            timerARunning <= runA;
            timerBRunning <= runB;
        end
    end

    // only the counter-mode path lives here; timer mode ticks are elsewhere
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timerACount <= COUNT_W'(TPX_COUNT_RESET);
            timerBCount <= COUNT_W'(TPX_COUNT_RESET);
        end else begin
            if (runA && timer_a_counter_mode && cntA.fall) begin
                timerACount <= timerACount + 1'b1;
            end
            if (runB && timer_b_counter_mode && cntB.fall) begin
                timerBCount <= timerBCount + 1'b1;
            end
        end
    end
endmodule

// ===== sim/testbench.sv
/* directed bench for the timer pin block with a pin source model.
   assumes checker and pin model are compiled first. */
`timescale 1ns/1ps
module testbench
    import tpx_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, wrEn = 1'b0;
    logic [1:0]  run = 2'h0, gate = 2'h0, cmode = 2'h0, ack = 2'h0, pend, running;
    logic [7:0]  wrData = 8'h00, ctrl;
    logic [3:0]  pins;
    logic [15:0] cntA, cntB;
    int          err_total = 0, n_compared = 0, cycles = 0;
    tpx_pin_src src (.clk(clk), .pins(pins));
    tpx_timer_pins dut (
        .clk(clk), .rst(rst), .ext_irq_pin_a(pins[0]), .ext_irq_pin_b(pins[1]), .timer_a_count_pin(pins[2]),
        .timer_b_count_pin(pins[3]), .timer_a_run(run[0]), .timer_b_run(run[1]), .timer_a_gate_sel(gate[0]),
        .timer_b_gate_sel(gate[1]), .timer_a_counter_mode(cmode[0]), .timer_b_counter_mode(cmode[1]),
        .ctrlWrEn(wrEn), .ctrlWrData(wrData), .ext_irq_ack_a(ack[0]), .ext_irq_ack_b(ack[1]),
        .timer_control_reg(ctrl), .ext_irq_pending_a(pend[0]), .ext_irq_pending_b(pend[1]),
        .timerARunning(running[0]), .timerBRunning(running[1]), .timerACount(cntA), .timerBCount(cntB));
    always #4 clk = ~clk;
    // ----------------------------
    // helpers
    // ----------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge clk) begin wrEn <= 1'b1; wrData <= d; end
        @(posedge clk) wrEn <= 1'b0;
        tick(2);
    endtask
    task automatic pulse_ack(input int i);
        @(posedge clk) ack[i] <= 1'b1;
        @(posedge clk) ack[i] <= 1'b0;
        tick(5);
    endtask
    // ----------------------------
    // scenarios
    // ----------------------------
    task automatic t_count();
        chk("ctrl reset", 16'(TPX_CTRL_RESET), 16'(ctrl));
        @(posedge clk) begin run <= 2'h3; cmode <= 2'h3; end
        repeat (3) src.pulse(2, 2);
        src.pulse(3, 6);
        tick(4);
        chk("count a", 16'h0003, cntA);
        chk("count b long low", 16'h0001, cntB);
        @(posedge clk) run <= 2'h0;
        src.pulse(2, 2);
        tick(4);
        chk("count a stopped", 16'h0003, cntA);
    endtask
    task automatic t_gate();
        @(posedge clk) begin run <= 2'h3; cmode <= 2'h0; gate <= 2'h3; end
        tick(5);
        chk("running open", 16'h0003, 16'(running));
        fork
            src.pulse(0, 8);
            begin tick(6); chk("running shut", 16'h0002, 16'(running)); end
        join
        src.pulse(2, 2);
        tick(4);
        chk("count a timer mode", 16'h0003, cntA);
    endtask
    task automatic t_edge();
        wr(8'h05);
        chk("ctrl edge sel", 16'h0005, 16'(ctrl));
        fork
            src.pulse(1, 16);
            begin
                tick(8);
                chk("pend edge", 16'h0002, 16'(pend));
                chk("running b shut", 16'h0001, 16'(running));
                pulse_ack(1);
                chk("pend edge held low", 16'h0000, 16'(pend));
            end
        join
    endtask
    task automatic t_level();
        wr(8'h00);
        fork
            src.pulse(0, 16);
            begin tick(8); pulse_ack(0); chk("ctrl level low", 16'h0002, 16'(ctrl)); end
        join
        wr(8'h00);
        chk("ctrl cleared", 16'h0000, 16'(ctrl));
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        t_count();
        t_gate();
        t_edge();
        t_level();
        close_out();
    end
endmodule
bind tpx_timer_pins tpx_asserts #(.COUNT_W(COUNT_W)) chk_a (.clk, .rst, .ext_irq_pin_a, .timer_a_run,
    .timer_a_gate_sel, .ctrlWrEn, .ctrlWrData, .timer_control_reg, .ext_irq_pending_a, .timerARunning, .timerACount);

// ===== sim/tpx_asserts.sv
/* checker for the timer pin block, bound to its top module.
   assumes one clock and an async active-high reset. */
`timescale 1ns/1ps
module tpx_asserts
    import tpx_pkg::*;
#(
    parameter int COUNT_W = TPX_COUNT_W
)
(
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    // inputs seen
    input wire logic                  ext_irq_pin_a,
    input wire logic                  timer_a_run,
    input wire logic                  timer_a_gate_sel,
    input wire logic                  ctrlWrEn,
    input wire logic [TPX_CTRL_W-1:0] ctrlWrData,
    // outputs seen
    input wire logic [TPX_CTRL_W-1:0] timer_control_reg,
    input wire logic                  ext_irq_pending_a,
    input wire logic                  timerARunning,
    input wire logic [COUNT_W-1:0]    timerACount
);
    // ----------------------------
    // channel a relations
    // ----------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wr; ctrlWrEn ##1 !ctrlWrEn [*2]; endsequence
    sequence s_shut; (timer_a_gate_sel && !ext_irq_pin_a) [*4]; endsequence
    property p_edge_rb;
        s_wr |-> timer_control_reg[TPX_BIT_EDGE_A] == $past(ctrlWrData[TPX_BIT_EDGE_A], 2);
    endproperty
    a_edge_rb: assert property (p_edge_rb) else $error("edge select readback wrong");
    property p_mirror; timer_control_reg[TPX_BIT_PEND_A] == ext_irq_pending_a; endproperty
    a_mirror: assert property (p_mirror) else $error("pending bit not in control reg");
    property p_spare; timer_control_reg[7:4] == 4'h0; endproperty
    a_spare: assert property (p_spare) else $error("spare control bits set");
    property p_shut; s_shut |-> !timerARunning; endproperty
    a_shut: assert property (p_shut) else $error("timer runs with gate closed");
    property p_open; (timer_a_run && !timer_a_gate_sel) [*3] |-> timerARunning; endproperty
    a_open: assert property (p_open) else $error("ungated timer not running");
    property p_level; (!timer_control_reg[TPX_BIT_EDGE_A] && !ext_irq_pin_a) [*6] |-> ext_irq_pending_a; endproperty
    a_level: assert property (p_level) else $error("low level did not set pending");
    property p_step; timerACount == $past(timerACount) || timerACount == $past(timerACount) + 1'b1; endproperty
    a_step: assert property (p_step) else $error("count moved by more than one");
    // a pending rise needs a low pin a few cycles back, through the synchroniser
    property p_src;
        $rose(ext_irq_pending_a) |-> !$past(ext_irq_pin_a, 3) || !$past(ext_irq_pin_a, 4) || !$past(ext_irq_pin_a, 5);
    endproperty
    a_src: assert property (p_src) else $error("pending set without a low pin");
endmodule

// ===== sim/tpx_pin_src.sv
/* pin source model: drives both interrupt pins and both count pins.
   assumes pull-ups, so an idle pin reads high. */
`timescale 1ns/1ps
module tpx_pin_src (
    // clock
    input  wire logic clk,
    // irq a, irq b, count a, count b
    output logic [3:0] pins
);
    initial pins = 4'hf;
    // three high cycles after each pulse so no two falls merge
    task automatic pulse(input int idx, input int lo);
        @(posedge clk) pins[idx] <= 1'b0;
        repeat (lo) @(posedge clk);
        pins[idx] <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
endmodule
